// >>> cec_rx_pkg.sv
package cec_rx_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] RX_ENABLE_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;

  // Control register field positions
  localparam int LATE_ZERO_LSB = 20;
  localparam int EARLY_ZERO_LSB = 16;
  localparam int LATE_ONE_LSB = 12;
  localparam int EARLY_ONE_LSB = 8;
  localparam int START_EN_BIT = 1;
  localparam int WAVE_EN_BIT = 0;
  localparam logic [31:0] CTRL_RW_MASK = 32'h0077_7703;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Status register field positions
  localparam int STAT_WAVE_ERR_BIT = 0;
  localparam int STAT_START_BIT = 1;
  localparam int STAT_ACTIVE_BIT = 2;

  // Base limits in fs periods
  localparam logic [7:0] LATE_ZERO_BASE = 8'h38;
  localparam logic [7:0] EARLY_ZERO_BASE = 8'h2B;
  localparam logic [7:0] LATE_ONE_BASE = 8'h1A;
  localparam logic [7:0] EARLY_ONE_BASE = 8'h0D;
  localparam logic [7:0] START_MIN_RISE = 8'h73;
  localparam logic [7:0] START_MAX_RISE = 8'h80;
  localparam logic [7:0] BIT_IDLE_LIMIT = 8'h9A;

  // Sampling rate and the divider derived from it
  localparam int CORE_CLK_HZ = 125_000_000;
  localparam int FS_HZ = 32_768;
  localparam int FS_DIV = CORE_CLK_HZ / FS_HZ;

  typedef struct packed {
    logic [7:0] late_zero;
    logic [7:0] early_zero;
    logic [7:0] late_one;
    logic [7:0] early_one;
  } limits_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    START_LOW,
    BIT_HIGH,
    DATA_LOW
  } rx_state_t;

endpackage

// >>> fs_line_sampler.sv
`timescale 1ns/100ps
module fs_line_sampler #(
  parameter int DIV = cec_rx_pkg::FS_DIV
) (
  input wire logic core_clk, // System clock
  input wire logic reset, // Async reset, active high
  input wire logic line_pin, // Raw bus line
  output logic fs_tick, // One-cycle pulse at fs
  output logic line_level // Synchronised line level
);

  // The divider counter is 16 bits wide
  if (DIV < 2 || DIV > 65536) begin : g_bad_div
    $error("fs_line_sampler: DIV must lie between 2 and 65536");
  end

  logic sync_first;
  logic [15:0] div_cnt;
  logic [15:0] next_div_cnt;
  logic next_tick;

  always_comb begin
    next_tick = 1'b0;
    next_div_cnt = div_cnt + 16'h0001;
    if (div_cnt == 16'(DIV - 1)) begin
      next_div_cnt = 16'h0000;
      next_tick = 1'b1;
    end
  end

  // Two flops keep the asynchronous line away from the timing logic
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync_first <= 1'b1;
      line_level <= 1'b1;
      div_cnt <= 16'h0000;
      fs_tick <= 1'b0;
    end else begin
      sync_first <= line_pin;
      line_level <= sync_first;
      div_cnt <= next_div_cnt;
      fs_tick <= next_tick;
    end
  end

endmodule

// >>> cec_rx_waveform_checker.sv
`timescale 1ns/100ps
// How it works
// - Late-zero limit is 56 plus field
// - Early-zero limit is 43 minus field
// - Late-one limit is 26 plus field
// - Early-one limit is 13 minus field
// - No rise by late-zero limit is error
// - Rise between late-one and early-zero errors
// - Rise before early-one limit is error
// - Waveform enable gates all error reports
// - Start-bit enable raises event on start bit
module cec_rx_waveform_checker #(
  parameter int FS_DIV = cec_rx_pkg::FS_DIV
) (
  input wire logic core_clk, // System clock, 125 MHz
  input wire logic reset, // Async reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic line_pin, // Bus line level
  output logic waveform_error_event, // Pulse on waveform error
  output logic start_bit_event, // Pulse on start bit seen
  output logic receive_active // Receiver inside a frame
);

  logic fs_tick;
  logic line_level;
  logic prev_level;
  logic fall;
  logic rise;

  fs_line_sampler #(.DIV(FS_DIV)) u_sampler (
    .core_clk(core_clk),
    .reset(reset),
    .line_pin(line_pin),
    .fs_tick(fs_tick),
    .line_level(line_level)
  );

  assign fall = fs_tick && prev_level && !line_level;
  assign rise = fs_tick && !prev_level && line_level;

  // Register file
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic receive_enable_bit;
  logic next_receive_enable_bit;
  logic wave_err_flag;
  logic next_wave_err_flag;
  logic start_flag;
  logic next_start_flag;
  logic [31:0] next_prdata;
  logic setup;
  logic wr;
  logic mapped;
  logic wave_err_pulse;
  logic start_pulse;
  logic waveform_error_enable;
  logic start_bit_detect_enable;
  cec_rx_pkg::limits_t lim;

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign mapped = (paddr == cec_rx_pkg::CTRL_OFFSET) ||
                  (paddr == cec_rx_pkg::RX_ENABLE_OFFSET) ||
                  (paddr == cec_rx_pkg::STATUS_OFFSET);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  assign waveform_error_enable = ctrl[cec_rx_pkg::WAVE_EN_BIT];
  assign start_bit_detect_enable = ctrl[cec_rx_pkg::START_EN_BIT];
  assign lim.late_zero = cec_rx_pkg::LATE_ZERO_BASE +
    {5'h00, ctrl[cec_rx_pkg::LATE_ZERO_LSB +: 3]};
  assign lim.early_zero = cec_rx_pkg::EARLY_ZERO_BASE -
    {5'h00, ctrl[cec_rx_pkg::EARLY_ZERO_LSB +: 3]};
  assign lim.late_one = cec_rx_pkg::LATE_ONE_BASE +
    {5'h00, ctrl[cec_rx_pkg::LATE_ONE_LSB +: 3]};
  assign lim.early_one = cec_rx_pkg::EARLY_ONE_BASE -
    {5'h00, ctrl[cec_rx_pkg::EARLY_ONE_LSB +: 3]};

  always_comb begin
    next_ctrl = ctrl;
    next_receive_enable_bit = receive_enable_bit;
    next_wave_err_flag = wave_err_flag;
    next_start_flag = start_flag;
    next_prdata = prdata;
    if (wr && paddr == cec_rx_pkg::CTRL_OFFSET) begin
      next_ctrl = pwdata & cec_rx_pkg::CTRL_RW_MASK;
    end
    if (wr && paddr == cec_rx_pkg::RX_ENABLE_OFFSET) begin
      next_receive_enable_bit = pwdata[0];
    end
    // Write one to clear; a new event in the same cycle wins
    if (wr && paddr == cec_rx_pkg::STATUS_OFFSET) begin
      if (pwdata[cec_rx_pkg::STAT_WAVE_ERR_BIT]) begin
        next_wave_err_flag = 1'b0;
      end
      if (pwdata[cec_rx_pkg::STAT_START_BIT]) begin
        next_start_flag = 1'b0;
      end
    end
    if (wave_err_pulse) begin
      next_wave_err_flag = 1'b1;
    end
    if (start_pulse) begin
      next_start_flag = 1'b1;
    end
    // Read data is captured in the setup phase so it leaves a flop
    if (setup) begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
        cec_rx_pkg::CTRL_OFFSET: next_prdata = ctrl;
        cec_rx_pkg::RX_ENABLE_OFFSET: next_prdata[0] = receive_enable_bit;
        cec_rx_pkg::STATUS_OFFSET: begin
          next_prdata[cec_rx_pkg::STAT_WAVE_ERR_BIT] = wave_err_flag;
          next_prdata[cec_rx_pkg::STAT_START_BIT] = start_flag;
          next_prdata[cec_rx_pkg::STAT_ACTIVE_BIT] = receive_active;
        end
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl <= cec_rx_pkg::CTRL_RESET;
      receive_enable_bit <= 1'b0;
      wave_err_flag <= 1'b0;
      start_flag <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      receive_enable_bit <= next_receive_enable_bit;
      wave_err_flag <= next_wave_err_flag;
      start_flag <= next_start_flag;
      prdata <= next_prdata;
    end
  end

  // Bit timing
  cec_rx_pkg::rx_state_t state;
  cec_rx_pkg::rx_state_t next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [7:0] t_now;
  logic next_prev_level;

  // Time of this tick counted from the falling edge, saturating
  assign t_now = (cnt == 8'hFF) ? cnt : cnt + 8'h01;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_prev_level = fs_tick ? line_level : prev_level;
    wave_err_pulse = 1'b0;
    start_pulse = 1'b0;
    unique case (state)
      cec_rx_pkg::RX_IDLE: begin
        if (receive_enable_bit && fall) begin
          next_state = cec_rx_pkg::START_LOW;
          next_cnt = 8'h00;
        end
      end
      cec_rx_pkg::START_LOW: begin
        if (fs_tick) begin
          next_cnt = t_now;
          if (rise) begin
            if (t_now >= cec_rx_pkg::START_MIN_RISE &&
                t_now <= cec_rx_pkg::START_MAX_RISE) begin
              next_state = cec_rx_pkg::BIT_HIGH;
              start_pulse = start_bit_detect_enable;
            end else begin
              next_state = cec_rx_pkg::RX_IDLE;
            end
          end else if (t_now > cec_rx_pkg::START_MAX_RISE) begin
            next_state = cec_rx_pkg::RX_IDLE;
          end
        end
      end
      cec_rx_pkg::BIT_HIGH: begin
        if (fall) begin
          next_state = cec_rx_pkg::DATA_LOW;
          next_cnt = 8'h00;
        end else if (fs_tick) begin
          next_cnt = t_now;
          if (t_now >= cec_rx_pkg::BIT_IDLE_LIMIT) begin
            next_state = cec_rx_pkg::RX_IDLE;
          end
        end
      end
      cec_rx_pkg::DATA_LOW: begin
        if (fs_tick) begin
          next_cnt = t_now;
          if (rise) begin
            next_state = cec_rx_pkg::BIT_HIGH;
            if (t_now < lim.early_one) begin
              wave_err_pulse = waveform_error_enable;
            end
            if (t_now > lim.late_one && t_now < lim.early_zero) begin
              wave_err_pulse = waveform_error_enable;
            end
          end else if (t_now >= lim.late_zero) begin
            wave_err_pulse = waveform_error_enable;
            next_state = cec_rx_pkg::RX_IDLE;
          end
          // A reported bit error ends the frame so the next start bit resyncs
          if (wave_err_pulse) begin
            next_state = cec_rx_pkg::RX_IDLE;
          end
        end
      end
    endcase
    // Settings are only safe to change with the receiver stopped
    if (!receive_enable_bit) begin
      next_state = cec_rx_pkg::RX_IDLE;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= cec_rx_pkg::RX_IDLE;
      cnt <= 8'h00;
      prev_level <= 1'b1;
      waveform_error_event <= 1'b0;
      start_bit_event <= 1'b0;
      receive_active <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      prev_level <= next_prev_level;
      waveform_error_event <= wave_err_pulse;
      start_bit_event <= start_pulse;
      receive_active <= (next_state != cec_rx_pkg::RX_IDLE);
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_late_zero_field: assert property (
    wr && paddr == cec_rx_pkg::CTRL_OFFSET |=>
      lim.late_zero == 8'h38 + {5'h00, $past(pwdata[22:20])})
    else $error("late zero limit wrong");
  a_early_zero_field: assert property (
    wr && paddr == cec_rx_pkg::CTRL_OFFSET |=>
      lim.early_zero == 8'h2B - {5'h00, $past(pwdata[18:16])})
    else $error("early zero limit wrong");
  a_late_one_field: assert property (
    wr && paddr == cec_rx_pkg::CTRL_OFFSET |=>
      lim.late_one == 8'h1A + {5'h00, $past(pwdata[14:12])})
    else $error("late one limit wrong");
  a_early_one_field: assert property (
    wr && paddr == cec_rx_pkg::CTRL_OFFSET |=>
      lim.early_one == 8'h0D - {5'h00, $past(pwdata[10:8])})
    else $error("early one limit wrong");
  a_late_zero_err: assert property (
    state == cec_rx_pkg::DATA_LOW && fs_tick && !rise && waveform_error_enable &&
      t_now == lim.late_zero |=> waveform_error_event && state == cec_rx_pkg::RX_IDLE)
    else $error("missing late zero error");
  a_gap_rise_err: assert property (
    state == cec_rx_pkg::DATA_LOW && rise && waveform_error_enable &&
      t_now > lim.late_one && t_now < lim.early_zero |=> waveform_error_event)
    else $error("missing gap rise error");
  a_early_rise_err: assert property (
    state == cec_rx_pkg::DATA_LOW && rise && waveform_error_enable &&
      t_now < lim.early_one |=> waveform_error_event)
    else $error("missing early rise error");
  a_good_one_ok: assert property (
    state == cec_rx_pkg::DATA_LOW && rise && receive_enable_bit && t_now >= lim.early_one &&
      t_now <= lim.late_one |=> !waveform_error_event ##0 state == cec_rx_pkg::BIT_HIGH)
    else $error("good one flagged");
  a_err_gated: assert property (
    waveform_error_event |-> $past(waveform_error_enable) && $past(state) ==
      cec_rx_pkg::DATA_LOW)
    else $error("error reported while disabled");
  a_start_event: assert property (
    state == cec_rx_pkg::START_LOW && rise && t_now >= cec_rx_pkg::START_MIN_RISE &&
      t_now <= cec_rx_pkg::START_MAX_RISE |=> start_bit_event == $past(start_bit_detect_enable))
    else $error("start event wrong");
  a_count_restart: assert property (
    state == cec_rx_pkg::BIT_HIGH && fall && receive_enable_bit |=>
      cnt == 8'h00 ##1 (cnt == 8'h00)[*2])
    else $error("bit counter not restarted");
  a_reserved_zero: assert property (
    setup && paddr == cec_rx_pkg::CTRL_OFFSET |=> (prdata & ~32'h0077_7703) == 32'h0000_0000)
    else $error("reserved bits not zero");

  c_start_seen: cover property (start_bit_event);
  c_wave_error: cover property (waveform_error_event);
  c_bit_accepted: cover property (state == cec_rx_pkg::DATA_LOW ##1
    state == cec_rx_pkg::BIT_HIGH && !waveform_error_event);
  c_unmapped: cover property (pslverr);

endmodule

// >>> cec_line_driver.sv
`timescale 1ns/100ps
module cec_line_driver #(
  parameter int DIV = 4
) (
  input wire logic core_clk, // System clock
  input wire logic go, // Start one frame
  input wire logic [7:0] start_low, // Start bit low time in fs ticks
  input wire logic [7:0] data_low, // Data bit low time in fs ticks
  output logic line_pin, // Bus line, pulled up when released
  output logic busy // Frame in progress
);
  localparam int START_LEN = 150;
  localparam int FRAME_LEN = 230;
  int cnt = 0;
  int sl = 0;
  int dl = 0;
  initial busy = 1'b0;
  always @(posedge core_clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      cnt <= 0;
      sl <= start_low * DIV;
      dl <= data_low * DIV;
    end else if (busy) begin
      cnt <= cnt + 1;
      if (cnt == FRAME_LEN * DIV - 1) busy <= 1'b0;
    end
  end
  // All edges sit on multiples of DIV from one start, so tick counts are exact
  assign line_pin = !(busy && (cnt < sl ||
    (cnt >= START_LEN * DIV && cnt < START_LEN * DIV + dl)));
endmodule

// >>> rx_bit_waveform_checker_test.sv
`timescale 1ns/100ps
`define check(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module rx_bit_waveform_checker_test;
  localparam int DIV = 4;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [7:0] sl;
    logic [7:0] dl;
    logic err;
  } row_t;
  localparam row_t ROWS [18] = '{
    '{32'h0000_0001, 8'h78, 8'h0C, 1'b1}, '{32'h0000_0001, 8'h78, 8'h0D, 1'b0},
    '{32'h0000_0001, 8'h78, 8'h1A, 1'b0}, '{32'h0000_0001, 8'h78, 8'h1B, 1'b1},
    '{32'h0000_0001, 8'h78, 8'h2A, 1'b1}, '{32'h0000_0001, 8'h78, 8'h2B, 1'b0},
    '{32'h0000_0001, 8'h78, 8'h37, 1'b0}, '{32'h0000_0001, 8'h78, 8'h3C, 1'b1},
    '{32'h0077_7701, 8'h78, 8'h05, 1'b1}, '{32'h0077_7701, 8'h78, 8'h06, 1'b0},
    '{32'h0077_7701, 8'h78, 8'h21, 1'b0}, '{32'h0077_7701, 8'h78, 8'h22, 1'b1},
    '{32'h0077_7701, 8'h78, 8'h24, 1'b0}, '{32'h0077_7701, 8'h78, 8'h3C, 1'b0},
    '{32'h0077_7701, 8'h78, 8'h46, 1'b1}, '{32'h0000_0002, 8'h73, 8'h05, 1'b0},
    '{32'h0000_0003, 8'h80, 8'h1E, 1'b1}, '{32'h0000_0003, 8'h6E, 8'h1E, 1'b0}};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic go = 1'b0;
  logic [7:0] start_low = 8'h00;
  logic [7:0] data_low = 8'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic line_pin;
  logic waveform_error_event;
  logic start_bit_event;
  logic receive_active;
  logic busy;
  logic [31:0] rd;
  logic perr;
  int mismatches = 0;
  int samples_checked = 0;
  int err_seen = 0;
  int start_seen = 0;
  int e0;
  int s0;

  cec_rx_waveform_checker #(.FS_DIV(DIV)) cec_rx_waveform_checker_inst (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_pin(line_pin), .waveform_error_event(waveform_error_event),
    .start_bit_event(start_bit_event), .receive_active(receive_active));
  cec_line_driver #(.DIV(DIV)) cec_line_driver_inst (.core_clk(core_clk), .go(go),
    .start_low(start_low), .data_low(data_low), .line_pin(line_pin), .busy(busy));

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (waveform_error_event === 1'b1) err_seen <= err_seen + 1;
    if (start_bit_event === 1'b1) start_seen <= start_seen + 1;
  end

  task automatic close_out;
    if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin mismatches++; close_out(); end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic launch(input logic [7:0] sl, input logic [7:0] dl);
    @(posedge core_clk);
    go <= 1'b1;
    start_low <= sl;
    data_low <= dl;
    @(posedge core_clk);
    go <= 1'b0;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin @(posedge core_clk); n++; end while (busy !== 1'b0 && n < 2000);
    if (busy !== 1'b0) begin mismatches++; close_out(); end
  endtask

  task automatic frame(input logic [7:0] sl, input logic [7:0] dl);
    launch(sl, dl);
    wait_idle();
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    apb(1'b0, cec_rx_pkg::CTRL_OFFSET, 32'h0000_0000);
    `check(rd, 32'h0000_0000)
    apb(1'b1, cec_rx_pkg::CTRL_OFFSET, 32'hFFFF_FFFF);
    apb(1'b0, cec_rx_pkg::CTRL_OFFSET, 32'h0000_0000);
    `check(rd, 32'h0077_7703)
    apb(1'b0, 8'h0C, 32'h0000_0000);
    `check({perr, rd}, {1'b1, 32'h0000_0000})
    for (int i = 0; i < 18; i++) begin
      apb(1'b1, cec_rx_pkg::RX_ENABLE_OFFSET, 32'h0000_0000);
      apb(1'b0, cec_rx_pkg::RX_ENABLE_OFFSET, 32'h0000_0000);
      `check(rd[0], 1'b0)
      apb(1'b1, cec_rx_pkg::CTRL_OFFSET, ROWS[i].ctrl);
      apb(1'b1, cec_rx_pkg::RX_ENABLE_OFFSET, 32'h0000_0001);
      e0 = err_seen;
      s0 = start_seen;
      frame(ROWS[i].sl, ROWS[i].dl);
      `check(err_seen - e0, int'(ROWS[i].err))
      `check(start_seen - s0, int'(ROWS[i].ctrl[1] && ROWS[i].sl >= 8'h73 && ROWS[i].sl <= 8'h80))
    end
    apb(1'b1, cec_rx_pkg::RX_ENABLE_OFFSET, 32'h0000_0000);
    apb(1'b0, cec_rx_pkg::STATUS_OFFSET, 32'h0000_0000);
    `check(rd[2:0], 3'b011)
    apb(1'b1, cec_rx_pkg::STATUS_OFFSET, 32'h0000_0003);
    apb(1'b0, cec_rx_pkg::STATUS_OFFSET, 32'h0000_0000);
    `check(rd[2:0], 3'b000)
    // A good zero leaves the receiver in the frame until the bit period runs out
    apb(1'b1, cec_rx_pkg::CTRL_OFFSET, 32'h0000_0001);
    apb(1'b1, cec_rx_pkg::RX_ENABLE_OFFSET, 32'h0000_0001);
    frame(8'h78, 8'h30);
    `check(receive_active, 1'b1)
    repeat (100 * DIV) @(posedge core_clk);
    `check(receive_active, 1'b0)
    // Clearing the enable mid-frame drops the frame at once
    e0 = err_seen;
    launch(8'h78, 8'h0C);
    repeat (20 * DIV) @(posedge core_clk);
    `check(receive_active, 1'b1)
    apb(1'b1, cec_rx_pkg::RX_ENABLE_OFFSET, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    `check(receive_active, 1'b0)
    wait_idle();
    `check(err_seen - e0, 0)
    // Reset in the middle of a frame
    apb(1'b1, cec_rx_pkg::RX_ENABLE_OFFSET, 32'h0000_0001);
    launch(8'h78, 8'h0C);
    repeat (20 * DIV) @(posedge core_clk);
    `check(receive_active, 1'b1)
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    `check({receive_active, waveform_error_event, start_bit_event, prdata}, 35'h0_0000_0000)
    reset <= 1'b0;
    wait_idle();
    `check(err_seen - e0, 0)
    `check(receive_active, 1'b0)
    apb(1'b0, cec_rx_pkg::CTRL_OFFSET, 32'h0000_0000);
    `check(rd, 32'h0000_0000)
    apb(1'b0, cec_rx_pkg::RX_ENABLE_OFFSET, 32'h0000_0000);
    `check(rd[0], 1'b0)
    close_out();
  end
endmodule
